//--- scp_pkg.sv
package scp_pkg;

  // ==========================================================================
  // Configuration byte layout
  // ==========================================================================
  localparam logic [7:0] SCP_CFG_OFFSET    = 8'h06;  // Register address on the serial port.
  localparam int         SCP_RST_BIT       = 7;
  localparam int         SCP_MODE_BIT      = 6;
  localparam int         SCP_PD_BIT        = 3;
  localparam int         SCP_RES_LSB       = 0;
  localparam int         SCP_RES_W         = 3;
  localparam logic [7:0] SCP_CFG_WMASK     = 8'hcf;  // Bits 5 and 4 always read as zero.
  localparam logic [2:0] SCP_RES_RESET     = 3'h4;
  localparam logic [7:0] SCP_CFG_RESET     = 8'h04;
  localparam logic [7:0] SCP_UNMAPPED_DATA = 8'h00;

  // ==========================================================================
  // Resolution codes and the counts per inch they select
  // ==========================================================================
  localparam logic [2:0] SCP_RES_400  = 3'h0;
  localparam logic [2:0] SCP_RES_500  = 3'h1;
  localparam logic [2:0] SCP_RES_600  = 3'h2;
  localparam logic [2:0] SCP_RES_800  = 3'h3;
  localparam logic [2:0] SCP_RES_1000 = 3'h4;
  localparam logic [2:0] SCP_RES_1200 = 3'h5;
  localparam logic [2:0] SCP_RES_1600 = 3'h6;
  localparam int         SCP_CPI_W    = 11;

  // ==========================================================================
  // Pin timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS      = 100;
  localparam int WAKE_PULSE_NS      = 1000;
  localparam int WAKE_PULSE_CYCLES  = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYCLES  = 4;

  // ==========================================================================
  // Register port and pin states
  // ==========================================================================
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scp_req_t;

  typedef enum logic [1:0] {
    SCP_PIN_IDLE,
    SCP_PIN_LEVEL,
    SCP_PIN_PULSE
  } scp_pin_st_t;

endpackage : scp_pkg

//--- scp_cpi_map.sv
`timescale 1ns/1ps

// ============================================================================
// Registered translation of the resolution code into counts per inch.
// ============================================================================
module scp_cpi_map
  import scp_pkg::*;
(
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  // Code in, resolution out.
  input  wire logic [SCP_RES_W-1:0] res_code_i,
  output logic      [SCP_CPI_W-1:0] cpi_o
);

  typedef struct packed {
    logic [SCP_CPI_W-1:0] cpi;
  } scp_map_st_t;

  scp_map_st_t st_ff;
  scp_map_st_t nxt_st;

  // Code 7 is undefined; it falls back to the default resolution.
  always_comb
  begin
    nxt_st = st_ff;
    case (res_code_i)
      SCP_RES_400:  nxt_st.cpi = 11'd400;   // see R9
      SCP_RES_500:  nxt_st.cpi = 11'd500;   // see R9
      SCP_RES_600:  nxt_st.cpi = 11'd600;   // see R9
      SCP_RES_800:  nxt_st.cpi = 11'd800;   // see R9
      SCP_RES_1000: nxt_st.cpi = 11'd1000;  // see R9
      SCP_RES_1200: nxt_st.cpi = 11'd1200;  // see R9
      SCP_RES_1600: nxt_st.cpi = 11'd1600;  // see R9
      default:      nxt_st.cpi = 11'd1000;
    endcase
  end

  // Register the mapped value.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff.cpi <= 11'd1000;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign cpi_o = st_ff.cpi;

endmodule : scp_cpi_map

//--- scp_config.sv
`timescale 1ns/1ps

// Operation
// R1 - Configuration byte holds reset bit 7, mode bit 6, power-down bit 3, resolution 2:0.
// R2 - Writing the reset bit as one performs a full chip reset.
// R3 - Mode bit defaults zero for motion level; one selects sleep-wake pulse.
// R4 - Motion mode drives the pin low while either displacement is nonzero.
// R5 - Motion mode returns the pin high once both displacements read zero.
// R6 - Wake mode emits one pulse when motion is seen during sleep.
// R7 - Controller reads motion flags, then X, then Y displacement.
// R8 - Power-down bit defaults zero; writing one enters power-down mode.
// R9 - Resolution code maps 000..110 to 400..1600 counts per inch, default 1000.
// R10 - Writers place zeros in bits 5 and 4; they read back as zero.

// ============================================================================
// Configuration register and motion/wake pin driver.
// ============================================================================
module scp_config
  import scp_pkg::*;
#(
  parameter int PULSE_CYCLES = WAKE_PULSE_CYCLES,
  parameter int RST_CYCLES   = RESET_HOLD_CYCLES
)
(
  // Clock and reset.
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  // Register port from the serial interface logic.
  input  scp_req_t                  req_i,
  output logic      [7:0]           rdata_o,
  // Sensor core state.
  input  wire logic                 dx_nonzero_i,
  input  wire logic                 dy_nonzero_i,
  input  wire logic                 sleep_active_i,
  input  wire logic                 motion_event_i,
  // Controls steering the sensor core.
  output logic                      chip_reset_o,
  output logic                      power_down_request_o,
  output logic                      wake_pin_mode_select_o,
  output logic      [SCP_RES_W-1:0] resolution_select_o,
  output logic      [SCP_CPI_W-1:0] cpi_o,
  // Motion/wake pin, active low.
  output logic                      motion_wake_pin_n_o
);

  // ==========================================================================
  // Block state
  // ==========================================================================
  typedef struct packed {
    logic                 rst_req;
    logic                 mode;
    logic                 pd;
    logic [SCP_RES_W-1:0] res;
    logic [7:0]           rdata;
    logic [7:0]           rst_cnt;
    logic [7:0]           pulse_cnt;
    logic                 pin_n;
    scp_pin_st_t          pin_st;
  } scp_state_t;

  // Counter loads, cut to the counter width on purpose.
  localparam logic [7:0] PULSE_LEN = 8'(PULSE_CYCLES);
  localparam logic [7:0] RST_LEN   = 8'(RST_CYCLES);

  scp_state_t st_ff;
  scp_state_t nxt_st;
  logic       hit;
  logic       pending;
  logic       wr_ok;

  // ==========================================================================
  // Request decode
  // ==========================================================================
  // Writes are refused while a chip reset runs, so a second write cannot cut the
  // reset short or leave fields that the closing restore would then overwrite.
  assign hit     = (req_i.addr == SCP_CFG_OFFSET);
  // Either displacement still holding data keeps the level pin asserted.
  assign pending = dx_nonzero_i | dy_nonzero_i;
  assign wr_ok   = req_i.wr && hit && (st_ff.rst_cnt == 8'h00);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    nxt_st = st_ff;
    // Register write; bits 5 and 4 are masked so stray ones never stick.
    if (wr_ok)
    begin
      nxt_st.rst_req = req_i.wdata[SCP_RST_BIT];                 // see R1
      nxt_st.mode    = req_i.wdata[SCP_MODE_BIT];                // see R1
      nxt_st.pd      = req_i.wdata[SCP_PD_BIT];                  // see R8
      nxt_st.res     = req_i.wdata[SCP_RES_LSB +: SCP_RES_W];    // see R1
      if (req_i.wdata[SCP_RST_BIT])
      begin
        nxt_st.rst_cnt = RST_LEN;                                // see R2
      end
    end
    // Readback shows live fields, reserved bits zero.
    // A read and a write in one cycle return the value from before the write.
    if (req_i.rd)
    begin
      if (hit)
      begin
        nxt_st.rdata = {st_ff.rst_req, st_ff.mode, 2'b00, st_ff.pd, st_ff.res} &
                       SCP_CFG_WMASK;                            // see R10
      end
      else
      begin
        nxt_st.rdata = SCP_UNMAPPED_DATA;
      end
    end
    // Self-clearing chip reset: hold for a few cycles, then restore defaults.
    // The pin is frozen meanwhile and comes back released; a displacement still
    // nonzero pulls it low again on the next cycle in motion level mode.
    if (st_ff.rst_cnt != 8'h00)
    begin
      nxt_st.rst_cnt = st_ff.rst_cnt - 8'h01;
      if (st_ff.rst_cnt == 8'h01)
      begin
        nxt_st.rst_req = 1'b0;                                   // see R2
        nxt_st.mode    = 1'b0;
        nxt_st.pd      = 1'b0;
        nxt_st.res     = SCP_RES_RESET;
        nxt_st.pin_st  = SCP_PIN_IDLE;
        nxt_st.pin_n   = 1'b1;
      end
    end
    // Pin behaviour; the pulse runs to completion even if the mode flips.
    // Limitation: a mode change in mid-pulse leaves the pin low until the count
    // runs out, so level indication resumes one idle cycle after that.
    if (st_ff.rst_cnt == 8'h00)
    begin
      case (st_ff.pin_st)
        SCP_PIN_IDLE:
        begin
          nxt_st.pin_n = 1'b1;
          if (!st_ff.mode && pending)
          begin
            nxt_st.pin_st = SCP_PIN_LEVEL;                       // see R4
            nxt_st.pin_n  = 1'b0;
          end
          else if (st_ff.mode && motion_event_i && sleep_active_i)
          begin
            nxt_st.pin_st    = SCP_PIN_PULSE;                    // see R6
            nxt_st.pin_n     = 1'b0;
            nxt_st.pulse_cnt = PULSE_LEN;
          end
        end
        SCP_PIN_LEVEL:
        begin
          if (st_ff.mode || !pending)
          begin
            nxt_st.pin_st = SCP_PIN_IDLE;                        // see R5
            nxt_st.pin_n  = 1'b1;
          end
        end
        SCP_PIN_PULSE:
        begin
          nxt_st.pulse_cnt = st_ff.pulse_cnt - 8'h01;
          if (st_ff.pulse_cnt <= 8'h01)
          begin
            nxt_st.pin_st = SCP_PIN_IDLE;                        // see R6
            nxt_st.pin_n  = 1'b1;
          end
        end
        // An illegal state code releases the pin and returns to idle.
        default:
        begin
          nxt_st.pin_st = SCP_PIN_IDLE;
          nxt_st.pin_n  = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Synchronous reset returns every field to its power-up default.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff.rst_req   <= 1'b0;
      st_ff.mode      <= 1'b0;                                   // see R3
      st_ff.pd        <= 1'b0;                                   // see R8
      st_ff.res       <= SCP_RES_RESET;                          // see R9
      st_ff.rdata     <= 8'h00;
      st_ff.rst_cnt   <= 8'h00;
      st_ff.pulse_cnt <= 8'h00;
      st_ff.pin_n     <= 1'b1;
      st_ff.pin_st    <= SCP_PIN_IDLE;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Resolution lookup
  // ==========================================================================
  // Registered resolution lookup for the motion engine.
  scp_cpi_map u_cpi_map (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .res_code_i (st_ff.res),
    .cpi_o      (cpi_o)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // All outputs come straight from state flops.
  assign rdata_o                = st_ff.rdata;
  assign chip_reset_o           = st_ff.rst_req;
  assign power_down_request_o   = st_ff.pd;
  assign wake_pin_mode_select_o = st_ff.mode;
  assign resolution_select_o    = st_ff.res;
  assign motion_wake_pin_n_o    = st_ff.pin_n;

endmodule : scp_config

//--- scp_chk.sv
`timescale 1ns/1ps

// =============================================================
// Checker for the configuration register and the motion pin.
module scp_chk
  import scp_pkg::*;
#(
  parameter int PULSE_CYCLES = WAKE_PULSE_CYCLES,
  parameter int RST_CYCLES   = RESET_HOLD_CYCLES
)
(
  // Clock, reset and register port.
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input scp_req_t                  req_i,
  input wire logic [7:0]           rdata_o,
  // Sensor core state.
  input wire logic                 dx_nonzero_i,
  input wire logic                 dy_nonzero_i,
  input wire logic                 sleep_active_i,
  input wire logic                 motion_event_i,
  // Controls and pin.
  input wire logic                 chip_reset_o,
  input wire logic                 power_down_request_o,
  input wire logic                 wake_pin_mode_select_o,
  input wire logic [SCP_RES_W-1:0] resolution_select_o,
  input wire logic [SCP_CPI_W-1:0] cpi_o,
  input wire logic                 motion_wake_pin_n_o
);
  logic [7:0] rst_run_ff;
  logic [7:0] pin_run_ff;
  logic       cfg_wr;

  // Run lengths are counted so long holds need no deep repetition.
  always_ff @(posedge clk_i)
  begin
    rst_run_ff <= (sys_rst_i || !chip_reset_o) ? 8'h00 : rst_run_ff + 8'h01;
    pin_run_ff <= (sys_rst_i || motion_wake_pin_n_o) ? 8'h00 : pin_run_ff + 8'h01;
  end

  // A write that hits the configuration byte.
  assign cfg_wr = req_i.wr && (req_i.addr == SCP_CFG_OFFSET);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  fld_write_a: assert property (cfg_wr && !req_i.wdata[7] && !chip_reset_o |=>
    {wake_pin_mode_select_o, power_down_request_o, resolution_select_o} ==
    {$past(req_i.wdata[6]), $past(req_i.wdata[3:0])}) else $error("field write lost");
  rd_back_a: assert property (req_i.rd && req_i.addr == SCP_CFG_OFFSET |=>
    rdata_o[6:0] == {$past(wake_pin_mode_select_o), 2'b00, $past(power_down_request_o),
    $past(resolution_select_o)}) else $error("read back differs");
  rst_start_a: assert property (cfg_wr && req_i.wdata[7] && !chip_reset_o |=>
    chip_reset_o) else $error("chip reset not started");
  rst_end_a: assert property ($fell(chip_reset_o) |-> rst_run_ff == RST_CYCLES
    && motion_wake_pin_n_o && {wake_pin_mode_select_o, power_down_request_o,
    resolution_select_o} == {2'b00, SCP_RES_RESET}) else $error("chip reset wrong");
  lvl_low_a: assert property (!wake_pin_mode_select_o && !chip_reset_o &&
    (dx_nonzero_i || dy_nonzero_i) ##1 !wake_pin_mode_select_o && !chip_reset_o
    |-> !motion_wake_pin_n_o) else $error("pin not low while pending");
  lvl_high_a: assert property (!wake_pin_mode_select_o && !chip_reset_o &&
    !dx_nonzero_i && !dy_nonzero_i ##1 !wake_pin_mode_select_o && !chip_reset_o
    |-> motion_wake_pin_n_o) else $error("pin not high when drained");
  wake_start_a: assert property (wake_pin_mode_select_o && sleep_active_i &&
    motion_event_i && motion_wake_pin_n_o && $past(motion_wake_pin_n_o) && !chip_reset_o
    |=> !motion_wake_pin_n_o) else $error("wake pulse missing");
  pulse_len_a: assert property ($rose(motion_wake_pin_n_o) &&
    wake_pin_mode_select_o |-> pin_run_ff == PULSE_CYCLES) else $error("pulse length wrong");
endmodule : scp_chk

bind scp_config scp_chk #(.PULSE_CYCLES(PULSE_CYCLES), .RST_CYCLES(RST_CYCLES)) scp_chk_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .dx_nonzero_i(dx_nonzero_i), .dy_nonzero_i(dy_nonzero_i), .sleep_active_i(sleep_active_i),
  .motion_event_i(motion_event_i), .chip_reset_o(chip_reset_o),
  .power_down_request_o(power_down_request_o), .wake_pin_mode_select_o(wake_pin_mode_select_o),
  .resolution_select_o(resolution_select_o), .cpi_o(cpi_o),
  .motion_wake_pin_n_o(motion_wake_pin_n_o));

//--- scp_ctl_model.sv
`timescale 1ns/1ps

// =============================================================
// Controller model: on a low pin it reads status, X, then Y.
module scp_ctl_model
  import scp_pkg::*;
#(
  parameter logic [7:0] STAT_ADDR = 8'h02  // Status address; X and Y follow it.
)
(
  // Clock and pin.
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic pin_n_i,
  // Reads and the displacement reads among them.
  output scp_req_t  req_o,
  output logic      x_rd_o,
  output logic      y_rd_o
);
  // Two idle edges after a burst give the pin time to rise first.
  initial
  begin
    req_o = '0;
    forever
    begin
      @(posedge clk_i);
      if (en_i && !pin_n_i)
      begin
        for (int k = 0; k < 3; k++)
        begin
          req_o <= '{1'b0, 1'b1, STAT_ADDR + 8'(k), 8'h00};
          @(posedge clk_i);
        end
        req_o <= '0;
        repeat (2) @(posedge clk_i);
      end
    end
  end

  // Reads of X and Y empty the matching displacement.
  assign x_rd_o = req_o.rd && (req_o.addr == STAT_ADDR + 8'h01);
  assign y_rd_o = req_o.rd && (req_o.addr == STAT_ADDR + 8'h02);
endmodule : scp_ctl_model

//--- tb.sv
`timescale 1ns/1ps

// =============================================================
// Bench: one task per scenario, each judging its own results.
module tb
  import scp_pkg::*;
;
  logic clk_i, sys_rst_i, dx_i, dy_i, sleep_i, mot_i, ctl_en, x_rd, y_rd;
  logic chip_rst, pd, mode, pin_n;
  logic [2:0] res;
  logic [7:0] rdata;
  logic [10:0] cpi;
  scp_req_t tb_req, ctl_req;
  int error_cnt = 0;
  int checks = 0;
  int n;
  int cpi_tab [7] = '{400, 500, 600, 800, 1000, 1200, 1600};

  scp_config #(.PULSE_CYCLES(10), .RST_CYCLES(4)) scp_config_i (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .req_i(tb_req | ctl_req), .rdata_o(rdata), .dx_nonzero_i(dx_i),
    .dy_nonzero_i(dy_i), .sleep_active_i(sleep_i), .motion_event_i(mot_i),
    .chip_reset_o(chip_rst), .power_down_request_o(pd), .wake_pin_mode_select_o(mode),
    .resolution_select_o(res), .cpi_o(cpi), .motion_wake_pin_n_o(pin_n));
  scp_ctl_model scp_ctl_model_i (.clk_i(clk_i), .en_i(ctl_en), .pin_n_i(pin_n),
    .req_o(ctl_req), .x_rd_o(x_rd), .y_rd_o(y_rd));

  // The 10 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Displacements empty as the controller reads them.
  always @(posedge clk_i)
  begin
    if (x_rd) dx_i <= 1'b0;
    if (y_rd) dy_i <= 1'b0;
  end

  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One register access; results have settled when it returns.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    tb_req <= '{w, !w, a, d};
    @(posedge clk_i);
    tb_req <= '0;
    @(posedge clk_i);
    #1;
  endtask : acc

  // Counts edges while the pin (on_pin) or the chip reset keeps a level, bounded.
  task automatic hold(input bit on_pin, input logic v);
    n = 0;
    while ((on_pin ? pin_n : chip_rst) === v && n < 40)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask : hold

  task automatic t_regs;
    acc(1'b0, SCP_CFG_OFFSET, 8'h00);
    chk("reset cfg", SCP_CFG_RESET, rdata);
    chk("reset cpi", 11'h3e8, cpi);
    acc(1'b1, SCP_CFG_OFFSET, 8'h4f);
    chk("fields", 5'h1f, {mode, pd, res});
    acc(1'b1, 8'h05, 8'h00);
    acc(1'b0, SCP_CFG_OFFSET, 8'h00);
    chk("readback", 8'h4f, rdata);
    acc(1'b0, 8'h05, 8'h00);
    chk("unmapped", SCP_UNMAPPED_DATA, rdata);
    for (int c = 0; c < 7; c++)
    begin
      acc(1'b1, SCP_CFG_OFFSET, 8'(c));
      chk("cpi", 11'(cpi_tab[c]), cpi);
    end
    acc(1'b1, SCP_CFG_OFFSET, 8'h07);
    chk("cpi code 7", 11'h3e8, cpi);
    $display("register test done");
  endtask : t_regs

  // The strobe was seen once inside acc, so three more cycles remain.
  task automatic t_chip_reset;
    acc(1'b1, SCP_CFG_OFFSET, 8'hcb);
    chk("reset strobe", 1'b1, chip_rst);
    hold(1'b0, 1'b1);
    chk("reset length", 3, n);
    @(posedge clk_i);
    #1;
    chk("restored", 5'h04, {mode, pd, res});
    chk("restored cpi", 11'h3e8, cpi);
    $display("chip reset test done");
  endtask : t_chip_reset

  task automatic t_level;
    @(posedge clk_i);
    ctl_en <= 1'b1;
    dx_i <= 1'b1;
    dy_i <= 1'b1;
    hold(1'b1, 1'b1);
    chk("pin low", 1'b0, pin_n);
    hold(1'b1, 1'b0);
    chk("pin high", 1'b1, pin_n);
    chk("y drained", 1'b0, dy_i);
    ctl_en <= 1'b0;
    $display("level test done");
  endtask : t_level

  task automatic t_pulse;
    acc(1'b1, SCP_CFG_OFFSET, 8'h40);
    @(posedge clk_i);
    mot_i <= 1'b1;
    @(posedge clk_i);
    mot_i <= 1'b0;
    sleep_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("awake event", 1'b1, pin_n);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      mot_i <= 1'b1;
      @(posedge clk_i);
      mot_i <= 1'b0;
      #1;
      hold(1'b1, 1'b0);
      chk("pulse length", 10, n);
    end
    $display("pulse test done");
  endtask : t_pulse

  task automatic give_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Main sequence.
  initial
  begin
    sys_rst_i = 1'b1;
    tb_req = '0;
    dx_i = 1'b0;
    dy_i = 1'b0;
    sleep_i = 1'b0;
    mot_i = 1'b0;
    ctl_en = 1'b0;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_chip_reset();
    t_level();
    t_pulse();
    give_verdict();
  end

  // The tests take some 90 cycles; the 2000-cycle limit, over twenty times that, means a hang.
  initial
  begin
    repeat (2000) @(posedge clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule : tb
